// file: hw/sieb_pkg.sv
package sieb_pkg;
  localparam int SIEB_NUM_STAGES = 12;
  localparam logic [9:0] SIEB_HIGH_EN_OFFSET = 10'h006;
  localparam logic [9:0] SIEB_DONE_EN_OFFSET = 10'h007;
  localparam logic [9:0] SIEB_HIGH_FLAG_OFFSET = 10'h009;
  localparam logic [9:0] SIEB_DONE_FLAG_OFFSET = 10'h00a;
  localparam logic [9:0] SIEB_PIN_FLAG_OFFSET = 10'h00b;
  localparam int SIEB_PIN_EN_BIT = 12;
  localparam logic [15:0] SIEB_HIGH_EN_MASK = 16'h0fff;
  localparam logic [15:0] SIEB_DONE_EN_MASK = 16'h1fff;
  localparam logic [15:0] SIEB_EN_RESET = 16'h0000;
  localparam logic [1:0] SIEB_PIN_MODE_INPUT = 2'h1;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [9:0] addr;
    logic [15:0] wrData;
  } sieb_reg_req_t;

  typedef struct packed {
    logic [11:0] stageDone;
    logic [11:0] stageHigh;
  } sieb_events_t;
endpackage : sieb_pkg

// file: hw/sieb_stage_irq_enable_bank.sv
`timescale 1ns/1ps
// How it works
// RL1: offset 0x006 bits 0-11 enable high events
// RL2: offset 0x007 bits 0-11 enable completion events
// RL3: bit 12 enables auxiliary pin change interrupt
// RL4: zero enable bit never asserts the interrupt
// RL5: host writes zero to unused bits
// RL6: enables reset to zero, read/write
// RL7: flags clear on read unless still exceeded
// RL8: pin change counts only in input mode
// RL9: irq low iff enabled source pending
module sieb_stage_irq_enable_bank
  import sieb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register access from the serial interface
  input wire sieb_reg_req_t regReq,
  output logic [15:0] rdData,
  // conversion events and limit levels
  input wire sieb_events_t events,
  input wire logic [11:0] stageHighLevel,
  // auxiliary pin
  input wire logic auxPinIn,
  input wire logic [1:0] auxPinSetup,
  // interrupt to host
  output logic irqOutN
);

  // ************************************************
  // enable registers
  // ************************************************
  logic [15:0] highEn_q;
  logic [15:0] highEn_d;
  logic [15:0] doneEn_q;
  logic [15:0] doneEn_d;
  logic highEnWrite;
  logic doneEnWrite;

  always_comb begin
    highEnWrite = regReq.wrEn && (regReq.addr == SIEB_HIGH_EN_OFFSET);
    doneEnWrite = regReq.wrEn && (regReq.addr == SIEB_DONE_EN_OFFSET);
    highEn_d = highEn_q;
    doneEn_d = doneEn_q;
    // unused bits stored as zero even if a host writes ones there
    if (highEnWrite) begin
      highEn_d = regReq.wrData & SIEB_HIGH_EN_MASK; // RL1 RL5
    end
    if (doneEnWrite) begin
      doneEn_d = regReq.wrData & SIEB_DONE_EN_MASK; // RL2 RL3 RL5
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      highEn_q <= SIEB_EN_RESET; // RL6
      doneEn_q <= SIEB_EN_RESET; // RL6
    end else begin
      highEn_q <= highEn_d;
      doneEn_q <= doneEn_d;
    end
  end

  // ************************************************
  // flag read strobes
  // ************************************************
  logic highFlagRead;
  logic doneFlagRead;
  logic pinFlagRead;

  // a read clears on the same edge that captures the read data
  always_comb begin
    highFlagRead = regReq.rdEn && (regReq.addr == SIEB_HIGH_FLAG_OFFSET); // RL7
    doneFlagRead = regReq.rdEn && (regReq.addr == SIEB_DONE_FLAG_OFFSET);
    pinFlagRead = regReq.rdEn && (regReq.addr == SIEB_PIN_FLAG_OFFSET);
  end

  // ************************************************
  // per-stage event flags
  // ************************************************
  wire logic [11:0] highFlagAll;
  wire logic [11:0] doneFlagAll;
  wire logic [11:0] highSrcPending;
  wire logic [11:0] doneSrcPending;

  for (genvar stage = 0; stage < SIEB_NUM_STAGES; stage++) begin : g_stage
    logic highFlag_q;
    logic highFlag_d;
    logic doneFlag_q;
    logic doneFlag_d;

    // set wins over read-clear, so an event in the read cycle is never lost
    always_comb begin
      highFlag_d = highFlag_q;
      doneFlag_d = doneFlag_q;
      if (highFlagRead) begin
        highFlag_d = highFlag_q & stageHighLevel[stage]; // RL7
      end
      if (doneFlagRead) begin
        doneFlag_d = 1'b0;
      end
      if (events.stageHigh[stage]) begin
        highFlag_d = 1'b1;
      end
      if (events.stageDone[stage]) begin
        doneFlag_d = 1'b1;
      end
    end

    always_ff @(posedge core_clk) begin
      if (srst) begin
        highFlag_q <= 1'b0;
        doneFlag_q <= 1'b0;
      end else begin
        highFlag_q <= highFlag_d;
        doneFlag_q <= doneFlag_d;
      end
    end

    assign highFlagAll[stage] = highFlag_q;
    assign doneFlagAll[stage] = doneFlag_q;
    assign highSrcPending[stage] = highFlag_q & highEn_q[stage]; // RL1 RL4
    assign doneSrcPending[stage] = doneFlag_q & doneEn_q[stage]; // RL2 RL4
  end

  // ************************************************
  // auxiliary pin change
  // ************************************************
  logic [1:0] pinSync_q;
  logic [1:0] pinSync_d;
  logic pinLast_q;
  logic pinLast_d;
  logic [2:0] pinArm_q;
  logic [2:0] pinArm_d;
  logic pinFlag_q;
  logic pinFlag_d;
  logic pinChange;

  // pin is asynchronous: only the second stage reads the first
  always_comb begin
    pinSync_d = {pinSync_q[0], auxPinIn};
    pinLast_d = pinSync_q[1];
    // no compare until both stages and the last level hold real samples,
    // so a pin idling high gives no false change after reset
    pinArm_d = {pinArm_q[1:0], 1'b1};
    pinChange = pinArm_q[2] && (pinSync_q[1] != pinLast_q) && (auxPinSetup == SIEB_PIN_MODE_INPUT); // RL8
    pinFlag_d = pinFlag_q;
    if (pinFlagRead) begin
      pinFlag_d = 1'b0;
    end
    // set wins over read-clear
    if (pinChange) begin
      pinFlag_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinSync_q <= 2'h0;
      pinLast_q <= 1'b0;
      pinArm_q <= 3'h0;
      pinFlag_q <= 1'b0;
    end else begin
      pinSync_q <= pinSync_d;
      pinLast_q <= pinLast_d;
      pinArm_q <= pinArm_d;
      pinFlag_q <= pinFlag_d;
    end
  end

  // ************************************************
  // read data
  // ************************************************
  logic [15:0] rdData_q;
  logic [15:0] rdData_d;

  // holds between reads so a slow host may pick it up late
  always_comb begin
    rdData_d = rdData_q;
    if (regReq.rdEn) begin
      case (regReq.addr)
        SIEB_HIGH_EN_OFFSET: begin
          rdData_d = highEn_q; // RL1 RL6
        end
        SIEB_DONE_EN_OFFSET: begin
          rdData_d = doneEn_q; // RL2 RL6
        end
        SIEB_HIGH_FLAG_OFFSET: begin
          rdData_d = {4'h0, highFlagAll};
        end
        SIEB_DONE_FLAG_OFFSET: begin
          rdData_d = {4'h0, doneFlagAll};
        end
        SIEB_PIN_FLAG_OFFSET: begin
          rdData_d = {15'h0, pinFlag_q};
        end
        default: begin
          rdData_d = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData_q <= 16'h0000;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // ************************************************
  // interrupt line
  // ************************************************
  logic irqOutN_q;
  logic irqOutN_d;
  logic pinSrcPending;
  logic pending;

  // registered so the pin never glitches while flags and enables change together
  always_comb begin
    pinSrcPending = pinFlag_q & doneEn_q[SIEB_PIN_EN_BIT]; // RL3 RL4
    pending = (|highSrcPending) | (|doneSrcPending) | pinSrcPending;
    irqOutN_d = ~pending; // RL9
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irqOutN_q <= 1'b1; // RL6
    end else begin
      irqOutN_q <= irqOutN_d;
    end
  end

  assign rdData = rdData_q;
  assign irqOutN = irqOutN_q;

endmodule : sieb_stage_irq_enable_bank

// file: dv/sieb_props.sv
`timescale 1ns/1ps
module sieb_props
  import sieb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register access
  input wire sieb_reg_req_t regReq,
  input wire logic [15:0] rdData,
  // events and pin
  input wire sieb_events_t events,
  input wire logic [11:0] stageHighLevel,
  input wire logic auxPinIn,
  input wire logic [1:0] auxPinSetup,
  // interrupt
  input wire logic irqOutN
);
  // ************************************************
  // reference copy of the enables
  // ************************************************
  logic [15:0] highEn_q, doneEn_q;
  always_ff @(posedge core_clk) begin
    highEn_q <= srst ? '0 : (regReq.wrEn && regReq.addr == 10'h6) ? regReq.wrData & SIEB_HIGH_EN_MASK : highEn_q;
    doneEn_q <= srst ? '0 : (regReq.wrEn && regReq.addr == 10'h7) ? regReq.wrData & SIEB_DONE_EN_MASK : doneEn_q;
  end
  // ************************************************
  // properties
  // ************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_highRd; regReq.rdEn && regReq.addr == 10'h6 |=> rdData == $past(highEn_q); endproperty
  a_highRd: assert property (p_highRd) else $error("high enable readback wrong");
  property p_doneRd; regReq.rdEn && regReq.addr == 10'h7 |=> rdData == $past(doneEn_q); endproperty
  a_doneRd: assert property (p_doneRd) else $error("done enable readback wrong");
  property p_hold; !regReq.rdEn |=> $stable(rdData); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_unmapped; regReq.rdEn && regReq.addr == 10'h0 |=> rdData == 16'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mask; (highEn_q == 16'h0 && doneEn_q == 16'h0) [*2] |=> irqOutN; endproperty
  a_mask: assert property (p_mask) else $error("interrupt with all sources off");
  property p_high; |(events.stageHigh & highEn_q[11:0]) |-> ##[1:3] !irqOutN; endproperty
  a_high: assert property (p_high) else $error("enabled high event gave no interrupt");
  property p_done; |(events.stageDone & doneEn_q[11:0]) |-> ##[1:3] !irqOutN; endproperty
  a_done: assert property (p_done) else $error("enabled done event gave no interrupt");
  property p_pin; $changed(auxPinIn) && auxPinSetup == SIEB_PIN_MODE_INPUT && doneEn_q[12] |-> ##[2:6] !irqOutN;
  endproperty
  a_pin: assert property (p_pin) else $error("pin change gave no interrupt");
endmodule : sieb_props
bind sieb_stage_irq_enable_bank sieb_props i_props(.core_clk(core_clk), .srst(srst), .regReq(regReq),
  .rdData(rdData), .events(events), .stageHighLevel(stageHighLevel), .auxPinIn(auxPinIn),
  .auxPinSetup(auxPinSetup), .irqOutN(irqOutN));

// file: dv/sieb_host_model.sv
`timescale 1ns/1ps
module sieb_host_model
  import sieb_pkg::*;
(
  // clock
  input wire logic core_clk,
  // register requests
  output sieb_reg_req_t regReq
);
  initial regReq = '0;
  // one-cycle strobe; data inverted after release so stale values never look valid
  task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d);
    @(negedge core_clk) regReq <= '{wrEn: w, rdEn: !w, addr: a, wrData: d};
    @(negedge core_clk) regReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
  endtask : xfer
endmodule : sieb_host_model

// file: dv/test_sieb_stage_irq_enable_bank.sv
`timescale 1ns/1ps
module test_sieb_stage_irq_enable_bank import sieb_pkg::*;;
  logic core_clk = 0, srst = 1, auxPinIn = 0, irqOutN;
  logic [1:0] auxPinSetup = 2'h1;
  logic [11:0] stageHighLevel = '0;
  logic [15:0] rdData;
  sieb_events_t events = '0;
  sieb_reg_req_t regReq;
  int miscompares = 0, checksDone = 0;
  initial forever #5 core_clk = ~core_clk;
  sieb_host_model i_host(.core_clk(core_clk), .regReq(regReq));
  sieb_stage_irq_enable_bank i_dut(.core_clk(core_clk), .srst(srst), .regReq(regReq), .rdData(rdData),
    .events(events), .stageHighLevel(stageHighLevel), .auxPinIn(auxPinIn), .auxPinSetup(auxPinSetup),
    .irqOutN(irqOutN));
  // ************************************************
  // helpers
  // ************************************************
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, exp, got);
    end
  endtask : chk

  // read data stands from the edge after the strobe, so it is checked at release
  task automatic rd(logic [9:0] a, logic [15:0] e);
    i_host.xfer(1'b0, a, 16'h0);
    chk("rdData", rdData, e);
  endtask : rd

  task automatic wr(logic [9:0] a, logic [15:0] d);
    i_host.xfer(1'b1, a, d);
  endtask : wr

  task automatic irq(logic e, int n);
    repeat (n) @(negedge core_clk);
    chk("irqOutN", {15'h0, irqOutN}, {15'h0, e});
  endtask : irq

  task automatic pulse(sieb_events_t e);
    @(negedge core_clk);
    events = e;
    @(negedge core_clk);
    events = '0;
  endtask : pulse

  // ************************************************
  // scenarios
  // ************************************************
  task automatic s_reset;
    rd(10'h6, 16'h0);
    rd(10'h7, 16'h0);
    rd(10'h0, 16'h0);
    irq(1, 0);
  endtask : s_reset

  task automatic s_regs;
    wr(10'h6, 16'h0fff);
    wr(10'h7, 16'h1fff);
    rd(10'h6, 16'h0fff);
    rd(10'h7, 16'h1fff);
    wr(10'h6, 16'h0a5c);
    wr(10'h7, 16'h15a3);
    rd(10'h6, 16'h0a5c);
    rd(10'h7, 16'h15a3);
    wr(10'h6, 16'h0);
    wr(10'h7, 16'h0);
    rd(10'h6, 16'h0);
    rd(10'h7, 16'h0);
  endtask : s_regs

  task automatic s_mask;
    pulse('1);
    irq(1, 4);
    rd(10'h9, 16'h0fff);
    rd(10'ha, 16'h0fff);
    rd(10'hb, 16'h0);
  endtask : s_mask

  task automatic s_high;
    wr(10'h6, 16'h0001);
    pulse('{stageDone: 12'h0, stageHigh: 12'h2});
    irq(1, 3);
    rd(10'h9, 16'h2);
    pulse('{stageDone: 12'h0, stageHigh: 12'h1});
    irq(0, 3);
    stageHighLevel = 12'h1;
    rd(10'h9, 16'h1);
    rd(10'h9, 16'h1);
    stageHighLevel = 12'h0;
    rd(10'h9, 16'h1);
    rd(10'h9, 16'h0);
    irq(1, 2);
    wr(10'h6, 16'h0);
  endtask : s_high

  task automatic s_done;
    wr(10'h7, 16'h0800);
    pulse('{stageDone: 12'h800, stageHigh: 12'h0});
    irq(0, 3);
    rd(10'ha, 16'h0800);
    irq(1, 2);
  endtask : s_done

  // reset in mid-run with an interrupt pending
  task automatic s_rst2;
    wr(10'h6, 16'h0fff);
    wr(10'h7, 16'h1fff);
    pulse('{stageDone: 12'h001, stageHigh: 12'h0});
    irq(0, 3);
    srst = 1;
    irq(1, 2);
    srst = 0;
    rd(10'h6, 16'h0);
    rd(10'h7, 16'h0);
    rd(10'ha, 16'h0);
    irq(1, 0);
  endtask : s_rst2

  task automatic s_pin;
    wr(10'h7, 16'h0000);
    auxPinIn = 1;
    irq(1, 6);
    rd(10'hb, 16'h1);
    wr(10'h7, 16'h1000);
    auxPinIn = 0;
    irq(0, 6);
    rd(10'hb, 16'h1);
    irq(1, 2);
    auxPinSetup = 2'h0;
    auxPinIn = 1;
    irq(1, 6);
    rd(10'hb, 16'h0);
  endtask : s_pin

  // ************************************************
  // verdict
  // ************************************************
  task automatic complete_run;
    if (miscompares == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (12) @(negedge core_clk);
    srst = 0;
    s_reset;
    s_regs;
    s_mask;
    s_high;
    s_done;
    s_rst2;
    s_pin;
    complete_run;
  end

  // scenarios need well under 1,000 cycles; this allows ten times that
  initial begin
    #100us;
    miscompares++;
    complete_run;
  end
endmodule : test_sieb_stage_irq_enable_bank
